// ===== hdl/spd_pkg.sv
// Setpoint detection package: register map, field codes, timing counts
// Assumes APB with 32-bit data and a 10 MHz block clock
package spd_pkg;
   localparam int NUM_SPT = 16;
   localparam int SAMPLE_W = 16;
   localparam int ADDR_W = 12;
   // Global registers (byte addresses)
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] STATE_OFS = 12'h008;
   // Setpoint block: base + index * 0x10
   localparam logic [3:0] SPT_PAGE = 4'h1;
   localparam logic [1:0] SPT_LIMITS = 2'h0;
   localparam logic [1:0] SPT_CFG = 2'h1;
   localparam logic [1:0] SPT_VAL1 = 2'h2;
   localparam logic [1:0] SPT_VAL2 = 2'h3;
   // Field positions
   localparam int CTRL_TRIG_WAIT_BIT = 0;
   localparam int LIM_UPPER_LSB = 16;
   localparam int LIM_LOWER_LSB = 0;
   localparam int CFG_CRIT_LSB = 0;
   localparam int CFG_MODE_LSB = 4;
   localparam int CFG_TGT_LSB = 8;
   // Criterion codes
   localparam logic [2:0] CRIT_INSIDE = 3'h0;
   localparam logic [2:0] CRIT_OUTSIDE = 3'h1;
   localparam logic [2:0] CRIT_GREATER = 3'h2;
   localparam logic [2:0] CRIT_LESS = 3'h3;
   localparam logic [2:0] CRIT_EQUAL = 3'h4;
   localparam logic [2:0] CRIT_HYST = 3'h5;
   // Update modes
   localparam logic [1:0] MODE_NONE = 2'h0;
   localparam logic [1:0] MODE_TRUE = 2'h1;
   localparam logic [1:0] MODE_BOTH = 2'h2;
   // Output targets
   localparam logic [1:0] TGT_NONE = 2'h0;
   localparam logic [1:0] TGT_DOUT_HIGH = 2'h1;
   localparam logic [1:0] TGT_AO0 = 2'h2;
   localparam logic [1:0] TGT_AO1 = 2'h3;
   // Reset values
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Timing: output update bound after sampling
   localparam int CLK_PERIOD_NS = 100;
   localparam int DOUT_XFER_NS = 250;
   localparam int DOUT_XFER_CYC = (DOUT_XFER_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                  DOUT_XFER_NS / CLK_PERIOD_NS;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT_TRIG, ST_RUN} spd_state_t;
endpackage

// ===== hdl/spd_core.sv
// Setpoint detection and output update core with APB register access
// Assumes scan samples arrive synchronous to MCLK_IN, one word per cycle
// Operation
// - Inside: true when lower limit < sample < upper limit.
// - Outside: true when sample above upper or below lower limit.
// - Greater: true when sample above lower limit; upper ignored.
// - Less: true when sample below upper limit; lower ignored.
// - Equal: true when sample equals upper limit.
// - Hysteresis: above upper forces value 2, below lower forces value 1.
// - Hysteresis inside window leaves flag and forced output unchanged.
// - Hysteresis updates happen regardless of update mode.
// - True-only mode writes value 1 when met, nothing otherwise.
// - True-and-false writes value 1 when met, value 2 when not.
// - Each setpoint holds two values: 16-bit analog code or byte.
// - Target is none, digital output high byte, or an analog output.
// - Detect flags are published once per scan period.
// - One setpoint per scan slot, sixteen at most.
// - Only 16-bit words compare; each counter word has its own slot.
// - With trigger wait set, evaluation begins at the trigger.
// - Shared output carries the value of the setpoint that wrote it last.
// - Flag is 1 when the criterion is met, 0 when not.
// - Status word holds setpoint 0 in bit 0, setpoint 15 in bit 15.
// - Output writes land within one sample period plus transfer time.
`timescale 1ns/1ns
`default_nettype none
module spd_core (
   // Clock and reset
   input wire logic MCLK_IN,
   input wire logic RST_N_IN,
   // APB slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // Acquisition control
   input wire logic ACQ_START_IN,
   input wire logic ACQ_STOP_IN,
   input wire logic TRIGGER_IN,
   // Scan sample stream
   input wire logic SAMPLE_VALID_IN,
   input wire logic [3:0] SAMPLE_SLOT_IN,
   input wire logic [15:0] SAMPLE_DATA_IN,
   input wire logic SCAN_END_IN,
   // Detection and output updates
   output logic [15:0] DET_FLAGS_OUT,
   output logic [7:0] DOUT_HIGH_OUT,
   output logic DOUT_HIGH_WE_OUT,
   output logic [15:0] FIRST_ANALOG_OUTPUT_OUT,
   output logic FIRST_ANALOG_OUTPUT_WE_OUT,
   output logic [15:0] SECOND_ANALOG_OUTPUT_OUT,
   output logic SECOND_ANALOG_OUTPUT_WE_OUT
);
   typedef struct packed {
      spd_pkg::spd_state_t st;
      logic trig_wait;
      logic [15:0][15:0] upper;
      logic [15:0][15:0] lower;
      logic [15:0][2:0] crit;
      logic [15:0][1:0] mode;
      logic [15:0][1:0] tgt;
      logic [15:0][15:0] val1;
      logic [15:0][15:0] val2;
      logic [15:0] seen;
      logic [15:0] last;
      logic [15:0] hyst_valid;
      logic [15:0] hyst_high;
      logic [15:0] pend;
      logic [15:0] det;
      logic [7:0] dout;
      logic dout_we;
      logic [15:0] ao0;
      logic ao0_we;
      logic [15:0] ao1;
      logic ao1_we;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } spd_regs_t;

   spd_regs_t s;
   spd_regs_t next_s;
   logic eval;
   logic [3:0] k;

   function automatic logic spd_cond(input logic [2:0] c,
         input logic [15:0] x, input logic [15:0] up,
         input logic [15:0] lo);
      case (c)
         spd_pkg::CRIT_INSIDE: spd_cond = (x > lo) && (x < up);
         spd_pkg::CRIT_OUTSIDE: spd_cond = (x > up) || (x < lo);
         spd_pkg::CRIT_GREATER: spd_cond = x > lo;
         spd_pkg::CRIT_LESS: spd_cond = x < up;
         spd_pkg::CRIT_EQUAL: spd_cond = x == up;
         default: spd_cond = 1'b0;
      endcase
   endfunction

   // Evaluation only while running and not restarting
   assign eval = (s.st == spd_pkg::ST_RUN) && SAMPLE_VALID_IN &&
                 !ACQ_START_IN;
   assign k = SAMPLE_SLOT_IN;

   always_comb begin
      logic c;
      logic wr;
      logic [15:0] v;
      logic [3:0] idx;
      logic [1:0] w;
      c = 1'b0;
      wr = 1'b0;
      v = 16'h0000;
      idx = PADDR_IN[7:4];
      w = PADDR_IN[3:2];
      next_s = s;
      next_s.dout_we = 1'b0;
      next_s.ao0_we = 1'b0;
      next_s.ao1_we = 1'b0;
      // APB: answer prepared in setup, completes in first access cycle
      next_s.pready = 1'b0;
      if (PSEL_IN && !PENABLE_IN) begin
         next_s.pready = 1'b1;
         next_s.pslverr = 1'b0;
         next_s.prdata = 32'h0000_0000;
         if (PADDR_IN == spd_pkg::CTRL_OFS) begin
            next_s.prdata[spd_pkg::CTRL_TRIG_WAIT_BIT] = s.trig_wait;
         end else if (PADDR_IN == spd_pkg::STATUS_OFS) begin
            next_s.prdata[15:0] = s.det;
         end else if (PADDR_IN == spd_pkg::STATE_OFS) begin
            next_s.prdata[1:0] = s.st;
         end else if (PADDR_IN[11:8] == spd_pkg::SPT_PAGE &&
                      PADDR_IN[1:0] == 2'h0) begin
            case (w)
               spd_pkg::SPT_LIMITS: next_s.prdata = {s.upper[idx],
                  s.lower[idx]};
               spd_pkg::SPT_CFG: next_s.prdata = {22'h000000, s.tgt[idx],
                  2'h0, s.mode[idx], 1'b0, s.crit[idx]};
               spd_pkg::SPT_VAL1: next_s.prdata[15:0] = s.val1[idx];
               default: next_s.prdata[15:0] = s.val2[idx];
            endcase
         end else begin
            next_s.pslverr = 1'b1;
         end
      end
      if (PSEL_IN && PENABLE_IN && s.pready && PWRITE_IN && !s.pslverr) begin
         if (PADDR_IN == spd_pkg::CTRL_OFS) begin
            next_s.trig_wait = PWDATA_IN[spd_pkg::CTRL_TRIG_WAIT_BIT];
         end else if (PADDR_IN[11:8] == spd_pkg::SPT_PAGE) begin
            case (w)
               spd_pkg::SPT_LIMITS: begin
                  next_s.upper[idx] = PWDATA_IN[spd_pkg::LIM_UPPER_LSB +: 16];
                  next_s.lower[idx] = PWDATA_IN[spd_pkg::LIM_LOWER_LSB +: 16];
               end
               spd_pkg::SPT_CFG: begin
                  next_s.crit[idx] = PWDATA_IN[spd_pkg::CFG_CRIT_LSB +: 3];
                  next_s.mode[idx] = PWDATA_IN[spd_pkg::CFG_MODE_LSB +: 2];
                  next_s.tgt[idx] = PWDATA_IN[spd_pkg::CFG_TGT_LSB +: 2];
               end
               spd_pkg::SPT_VAL1: next_s.val1[idx] = PWDATA_IN[15:0];
               default: next_s.val2[idx] = PWDATA_IN[15:0];
            endcase
         end
      end
      // Acquisition sequencing
      case (s.st)
         spd_pkg::ST_IDLE: ;
         spd_pkg::ST_WAIT_TRIG: begin
            if (TRIGGER_IN) begin
               next_s.st = spd_pkg::ST_RUN;
            end
         end
         spd_pkg::ST_RUN: begin
            if (ACQ_STOP_IN) begin
               next_s.st = spd_pkg::ST_IDLE;
            end
         end
         default: next_s.st = spd_pkg::ST_IDLE;
      endcase
      if (ACQ_START_IN) begin
         next_s.st = s.trig_wait ? spd_pkg::ST_WAIT_TRIG :
                     spd_pkg::ST_RUN;
         next_s.pend = 16'h0000;
         next_s.det = 16'h0000;
         next_s.seen = 16'h0000;
         next_s.hyst_valid = 16'h0000;
         next_s.hyst_high = 16'h0000;
      end else if (eval) begin
         if (s.crit[k] == spd_pkg::CRIT_HYST) begin
            // Forced update on entering a side, any update mode
            if (SAMPLE_DATA_IN > s.upper[k]) begin
               wr = !s.hyst_valid[k] || !s.hyst_high[k];
               v = s.val2[k];
               next_s.hyst_valid[k] = 1'b1;
               next_s.hyst_high[k] = 1'b1;
               next_s.pend[k] = 1'b1;
            end else if (SAMPLE_DATA_IN < s.lower[k]) begin
               wr = !s.hyst_valid[k] || s.hyst_high[k];
               v = s.val1[k];
               next_s.hyst_valid[k] = 1'b1;
               next_s.hyst_high[k] = 1'b0;
               next_s.pend[k] = 1'b0;
            end
         end else begin
            c = spd_cond(s.crit[k], SAMPLE_DATA_IN, s.upper[k],
                         s.lower[k]);
            next_s.pend[k] = c;
            next_s.seen[k] = 1'b1;
            next_s.last[k] = c;
            // Write on change only; a shared output keeps the last value written
            if (s.mode[k] == spd_pkg::MODE_TRUE) begin
               wr = c && (!s.seen[k] || !s.last[k]);
               v = s.val1[k];
            end else if (s.mode[k] == spd_pkg::MODE_BOTH) begin
               wr = !s.seen[k] || (c != s.last[k]);
               v = c ? s.val1[k] : s.val2[k];
            end
         end
         if (wr) begin
            case (s.tgt[k])
               spd_pkg::TGT_DOUT_HIGH: begin
                  next_s.dout = v[7:0];
                  next_s.dout_we = 1'b1;
               end
               spd_pkg::TGT_AO0: begin
                  next_s.ao0 = v;
                  next_s.ao0_we = 1'b1;
               end
               spd_pkg::TGT_AO1: begin
                  next_s.ao1 = v;
                  next_s.ao1_we = 1'b1;
               end
               default: ;
            endcase
         end
      end
      // Publish flags at scan end, including a last-slot update
      if (SCAN_END_IN && !ACQ_START_IN && s.st == spd_pkg::ST_RUN) begin
         next_s.det = next_s.pend;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign PRDATA_OUT = s.prdata;
   assign PREADY_OUT = s.pready;
   assign PSLVERR_OUT = s.pslverr;
   assign DET_FLAGS_OUT = s.det;
   assign DOUT_HIGH_OUT = s.dout;
   assign DOUT_HIGH_WE_OUT = s.dout_we;
   assign FIRST_ANALOG_OUTPUT_OUT = s.ao0;
   assign FIRST_ANALOG_OUTPUT_WE_OUT = s.ao0_we;
   assign SECOND_ANALOG_OUTPUT_OUT = s.ao1;
   assign SECOND_ANALOG_OUTPUT_WE_OUT = s.ao1_we;

   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RST_N_IN);

   AST_INSIDE: assert property (
      eval && s.crit[k] == spd_pkg::CRIT_INSIDE
      |=> s.pend[$past(k)] == ($past(SAMPLE_DATA_IN) > $past(s.lower[k])
      && $past(SAMPLE_DATA_IN) < $past(s.upper[k])))
      else $error("inside flag wrong");
   AST_OUTSIDE: assert property (
      eval && s.crit[k] == spd_pkg::CRIT_OUTSIDE
      && SAMPLE_DATA_IN > s.upper[k] |=> s.pend[$past(k)])
      else $error("outside flag not set");
   AST_GREATER: assert property (
      eval && s.crit[k] == spd_pkg::CRIT_GREATER
      && SAMPLE_DATA_IN <= s.lower[k] |=> !s.pend[$past(k)])
      else $error("greater flag set wrongly");
   AST_LESS: assert property (
      eval && s.crit[k] == spd_pkg::CRIT_LESS
      && SAMPLE_DATA_IN < s.upper[k] |=> s.pend[$past(k)])
      else $error("less flag not set");
   AST_EQUAL: assert property (
      eval && s.crit[k] == spd_pkg::CRIT_EQUAL
      && SAMPLE_DATA_IN == s.upper[k] |=> s.pend[$past(k)])
      else $error("equal flag not set");
   AST_HYST_HIGH: assert property (
      eval && s.crit[k] == spd_pkg::CRIT_HYST
      && SAMPLE_DATA_IN > s.upper[k] |=> s.hyst_high[$past(k)])
      else $error("hysteresis high not entered");
   AST_HYST_HOLD: assert property (
      eval && s.crit[k] == spd_pkg::CRIT_HYST
      && SAMPLE_DATA_IN <= s.upper[k] && SAMPLE_DATA_IN >= s.lower[k]
      |=> $stable(s.pend) && !DOUT_HIGH_WE_OUT && !FIRST_ANALOG_OUTPUT_WE_OUT
      && !SECOND_ANALOG_OUTPUT_WE_OUT)
      else $error("hysteresis changed inside window");
   AST_TRUE_ONLY: assert property (
      eval && s.crit[k] != spd_pkg::CRIT_HYST
      && s.mode[k] == spd_pkg::MODE_TRUE && !spd_cond(s.crit[k],
      SAMPLE_DATA_IN, s.upper[k], s.lower[k]) |=> !DOUT_HIGH_WE_OUT &&
      !FIRST_ANALOG_OUTPUT_WE_OUT && !SECOND_ANALOG_OUTPUT_WE_OUT)
      else $error("true-only wrote on false");
   AST_SCAN: assert property (
      !$past(SCAN_END_IN) && !$past(ACQ_START_IN)
      |-> $stable(DET_FLAGS_OUT))
      else $error("flags changed mid scan");
   AST_START: assert property (
      ACQ_START_IN |=> DET_FLAGS_OUT == 16'h0000
      && s.hyst_valid == 16'h0000)
      else $error("start did not clear");
   AST_TRIG: assert property (
      s.st == spd_pkg::ST_WAIT_TRIG && !TRIGGER_IN
      && !ACQ_START_IN |=> s.st == spd_pkg::ST_WAIT_TRIG)
      else $error("ran before trigger");

   COV_DOUT: cover property (eval ##1 DOUT_HIGH_WE_OUT);
   COV_AO1: cover property (SECOND_ANALOG_OUTPUT_WE_OUT ##[1:20]
      SECOND_ANALOG_OUTPUT_WE_OUT);
   COV_HYST: cover property (s.hyst_high != 16'h0000 ##[1:50]
      s.hyst_high == 16'h0000 && s.hyst_valid != 16'h0000);
   COV_FLAGS: cover property (SCAN_END_IN ##1 DET_FLAGS_OUT != 16'h0000);
endmodule // spd_core
`default_nettype wire

// ===== dv/spd_sampler_model.sv
// Scan sampler model: emits one scan word per request from the bench
// Assumes requests change just after a rising clock edge
`timescale 1ns/1ns
`default_nettype none
module spd_sampler_model (
   // Clock
   input wire logic clk_in,
   // Requests
   input wire logic go_in,
   input wire logic last_in,
   input wire logic [3:0] slot_in,
   input wire logic [15:0] data_in,
   // Scan stream
   output logic valid_out,
   output logic end_out,
   output logic [3:0] slot_out,
   output logic [15:0] data_out
);
   // Idle slots show inverted data so nothing stale looks valid
   always_ff @(posedge clk_in) begin
      valid_out <= go_in;
      end_out <= go_in & last_in;
      slot_out <= go_in ? slot_in : ~slot_out;
      data_out <= go_in ? data_in : ~data_out;
   end
endmodule // spd_sampler_model
`default_nettype wire

// ===== dv/setpoint_detect_output_update_tb.sv
// Bench for the setpoint core: APB setup, scans, output scoreboard
// Assumes spd_pkg, spd_core and spd_sampler_model are compiled first
`timescale 1ns/1ns
`default_nettype none
module setpoint_detect_output_update_tb;
   localparam logic [15:0] UP = 16'h8000;
   localparam logic [15:0] LO = 16'h1000;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd, rnd = 32'hB0EF;
   logic pready, pslverr, er, start = 1'b0, stop = 1'b0, trig = 1'b0;
   logic go = 1'b0, last = 1'b0, valid, send, live = 1'b1;
   logic [3:0] slot = 4'h0, sslot;
   logic [15:0] data = 16'h0, sdata, flags, ao0, ao1, exp_f = 16'h0;
   logic [7:0] dout;
   logic dwe, ao0we, ao1we;
   logic [2:0] crit[6];
   logic [1:0] mode[6], tgt[6], hy[6];
   logic [15:0] v1[6], v2[6];
   logic cond[6], seen[6];
   logic [17:0] q[$];
   logic [15:0] tbl[8] = '{16'h4000, 16'h1000, 16'h0FFF, 16'h8000,
                           16'h8001, 16'h4000, 16'h8001, 16'h0500};
   int n_fail = 0, num_checks = 0, cyc = 0;

   always #50 clk = ~clk;

   spd_core spd_core_inst (.MCLK_IN(clk), .RST_N_IN(rst_n),
      .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .ACQ_START_IN(start), .ACQ_STOP_IN(stop),
      .TRIGGER_IN(trig), .SAMPLE_VALID_IN(valid), .SAMPLE_SLOT_IN(sslot),
      .SAMPLE_DATA_IN(sdata), .SCAN_END_IN(send), .DET_FLAGS_OUT(flags),
      .DOUT_HIGH_OUT(dout), .DOUT_HIGH_WE_OUT(dwe),
      .FIRST_ANALOG_OUTPUT_OUT(ao0), .FIRST_ANALOG_OUTPUT_WE_OUT(ao0we),
      .SECOND_ANALOG_OUTPUT_OUT(ao1), .SECOND_ANALOG_OUTPUT_WE_OUT(ao1we));
   spd_sampler_model spd_sampler_model_inst (.clk_in(clk), .go_in(go),
      .last_in(last), .slot_in(slot), .data_in(data), .valid_out(valid),
      .end_out(send), .slot_out(sslot), .data_out(sdata));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
         n_fail++;
      end
   endtask

   task automatic give_verdict;
      if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic cfg(input int i, input logic [2:0] c, input logic [1:0] m,
                      input logic [1:0] t, input logic [15:0] a, b);
      logic [11:0] base;
      base = 12'h100 + 12'(i * 16);
      crit[i] = c;
      mode[i] = m;
      tgt[i] = t;
      v1[i] = a;
      v2[i] = b;
      apb(1'b1, base, {UP, LO});
      apb(1'b1, base + 12'h4, {22'h0, t, 2'h0, m, 1'h0, c});
      apb(1'b1, base + 12'h8, {16'h0, a});
      apb(1'b1, base + 12'hC, {16'h0, b});
   endtask

   // One-cycle pulse: 0 start, 1 trigger, 2 stop
   task automatic pulse(input int n);
      @(posedge clk);
      start <= n == 0;
      trig <= n == 1;
      stop <= n == 2;
      @(posedge clk);
      start <= 1'b0;
      trig <= 1'b0;
      stop <= 1'b0;
   endtask

   task automatic acq;
      pulse(0);
      for (int s = 0; s < 6; s++) begin
         cond[s] = 1'b0;
         seen[s] = 1'b0;
         hy[s] = 2'h0;
      end
      exp_f = 16'h0;
   endtask

   task automatic word(input int s, input logic [15:0] x, input logic l);
      logic c, w;
      logic [1:0] h;
      logic [15:0] v;
      @(posedge clk);
      go <= 1'b1;
      last <= l;
      slot <= 4'(s);
      data <= x;
      if (live !== 1'b1) return;
      if (crit[s] == spd_pkg::CRIT_HYST) begin
         h = x > UP ? 2'h2 : x < LO ? 2'h1 : hy[s];
         w = h != hy[s];
         c = h == 2'h2;
         v = c ? v2[s] : v1[s];
         hy[s] = h;
      end else begin
         case (crit[s])
            spd_pkg::CRIT_INSIDE: c = x > LO && x < UP;
            spd_pkg::CRIT_OUTSIDE: c = x > UP || x < LO;
            spd_pkg::CRIT_GREATER: c = x > LO;
            spd_pkg::CRIT_LESS: c = x < UP;
            default: c = x == UP;
         endcase
         w = mode[s] == spd_pkg::MODE_TRUE ? c && !cond[s] :
             mode[s] == spd_pkg::MODE_BOTH && (!seen[s] || c != cond[s]);
         v = c ? v1[s] : v2[s];
      end
      cond[s] = c;
      seen[s] = 1'b1;
      if (w && tgt[s] != spd_pkg::TGT_NONE)
         q.push_back({tgt[s], tgt[s] == spd_pkg::TGT_DOUT_HIGH ?
                      {8'h00, v[7:0]} : v});
   endtask

   task automatic scan(input logic [15:0] x);
      rnd = lfsr(rnd);
      for (int s = 0; s < 6; s++) begin
         if (rnd[s]) begin
            @(posedge clk);
            go <= 1'b0;
         end
         word(s, x, s == 5);
      end
      chk({16'h0, flags}, {16'h0, exp_f});
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
      for (int s = 0; s < 6; s++) exp_f[s] = cond[s];
      chk({16'h0, flags}, {16'h0, exp_f});
      chk(32'(q.size()), 32'h0);
   endtask

   task automatic mon(input logic [1:0] t, input logic [15:0] v);
      logic [17:0] e;
      e = q.size() > 0 ? q.pop_front() : 18'h3FFFF;
      chk({14'h0, t, v}, {14'h0, e});
   endtask

   always @(negedge clk) begin
      if (dwe === 1'b1) mon(spd_pkg::TGT_DOUT_HIGH, {8'h00, dout});
      if (ao0we === 1'b1) mon(spd_pkg::TGT_AO0, ao0);
      if (ao1we === 1'b1) mon(spd_pkg::TGT_AO1, ao1);
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc > 5000) begin
         n_fail++;
         give_verdict();
      end
   end

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, spd_pkg::CTRL_OFS, 32'h0);
      chk(rd, spd_pkg::CTRL_RESET);
      chk({31'h0, er}, 32'h0);
      apb(1'b1, 12'hFF0, 32'hFFFF_FFFF);
      chk({31'h0, er}, 32'h1);
      cfg(0, spd_pkg::CRIT_INSIDE, spd_pkg::MODE_BOTH,
          spd_pkg::TGT_DOUT_HIGH, 16'h0070, 16'h0030);
      cfg(1, spd_pkg::CRIT_OUTSIDE, spd_pkg::MODE_TRUE,
          spd_pkg::TGT_AO0, 16'h1234, 16'h5678);
      cfg(2, spd_pkg::CRIT_GREATER, spd_pkg::MODE_BOTH,
          spd_pkg::TGT_AO1, 16'hAAAA, 16'h5555);
      cfg(3, spd_pkg::CRIT_LESS, spd_pkg::MODE_NONE,
          spd_pkg::TGT_AO0, 16'hFFFF, 16'hEEEE);
      cfg(4, spd_pkg::CRIT_EQUAL, spd_pkg::MODE_TRUE,
          spd_pkg::TGT_NONE, 16'h0001, 16'h0002);
      cfg(5, spd_pkg::CRIT_HYST, spd_pkg::MODE_NONE,
          spd_pkg::TGT_AO1, 16'h0300, 16'h0700);
      acq();
      foreach (tbl[k]) scan(tbl[k]);
      repeat (6) scan(rnd[15:0]);
      apb(1'b0, spd_pkg::STATUS_OFS, 32'h0);
      chk(rd, {16'h0, exp_f});
      apb(1'b1, spd_pkg::CTRL_OFS, 32'h1);
      acq();
      apb(1'b0, spd_pkg::STATE_OFS, 32'h0);
      chk(rd, {30'h0, spd_pkg::ST_WAIT_TRIG});
      chk({16'h0, flags}, 32'h0);
      live = 1'b0;
      scan(16'h0500);
      pulse(1);
      live = 1'b1;
      apb(1'b0, spd_pkg::STATE_OFS, 32'h0);
      chk(rd, {30'h0, spd_pkg::ST_RUN});
      scan(16'h0500);
      pulse(2);
      apb(1'b0, spd_pkg::STATE_OFS, 32'h0);
      chk(rd, {30'h0, spd_pkg::ST_IDLE});
      give_verdict();
   end
endmodule // setpoint_detect_output_update_tb
`default_nettype wire
